// file: cmsd_map.svh
// How it works
// RL1: 256-byte internal RAM at 0x00..0xFF, register banks at the bottom.
// RL2: direct byte access at 0x80..0xFF goes to the special function space.
// RL3: pointer-indirect access at 0x80..0xFF reaches upper internal RAM only.
// RL4: 0x00..0x7F is one storage, reached alike by direct and indirect access.
// RL5: bit addresses 0x00..0x7F hit byte 0x20 + addr/8, bit addr[2:0].
// RL6: legacy power control at 0x87 ignores bit operations; whole bytes only.
// RL7: 2 kB extended RAM at 0x000..0x7FF, reached only by extended moves.
// RL8: no external bus cycles; code and extended data served on chip.
// RL9: code reads at accumulator plus pointer or pc take 4 cycles, jump 3.
// RL10: extended-direct uses the data pointer pair as address; read takes 4 cycles.
// RL11: extended-indirect uses a working register as address; read takes 4 cycles.
// RL12: immediate byte load takes 2 cycles, immediate word load 3 cycles.
// RL13: direct move 2 cycles, register move 1 cycle, pointer-indirect move 2.
// RL14: 20 GPIO pins on three bit-addressable port registers.
// RL15: per-pin pull-up enable; disabled means open drain, port zero always so.
// RL16: stack in extended RAM, start 0x100; three high bits set by start bits.
// RL17: extended addresses above 0x7FF alias on the low eleven bits.
`ifndef CMSD_MAP_SVH
`define CMSD_MAP_SVH

// special function space offsets
`define CMSD_SFR_PORT_ZERO    8'h80
`define CMSD_SFR_LEGACY_PWR   8'h87
`define CMSD_SFR_PORT_ONE     8'h90
`define CMSD_SFR_PORT_TWO     8'hA0
`define CMSD_SFR_STACK_HIGH   8'hB7
`define CMSD_SFR_POWER_MGMT   8'hC5
`define CMSD_SFR_PULLUP_ONE   8'hE1
`define CMSD_SFR_PULLUP_TWO   8'hE2

// address layout
`define CMSD_SFR_BASE         8'h80
`define CMSD_BIT_RAM_BASE     8'h20
`define CMSD_SSA_LSB          3
`define CMSD_SSA_MSB          5

// reset values
`define CMSD_RST_LEGACY_PWR   8'h00
`define CMSD_RST_POWER_MGMT   8'h00
`define CMSD_RST_STACK_HIGH   8'h08
`define CMSD_RST_PORT_LATCH   8'hFF
`define CMSD_RST_PULLUP       8'hFF
`define CMSD_CODE_BLANK       8'hFF

// sizes
`define CMSD_CODE_BYTES       63488
`define CMSD_EXTENDED_RAM_BYTES       2048
`define CMSD_PORT_TWO_PINS    4

// core cycles per access mode
`define CMSD_CYC_REG          4'h1
`define CMSD_CYC_DIRECT       4'h2
`define CMSD_CYC_INDIRECT     4'h2
`define CMSD_CYC_BIT          4'h2
`define CMSD_CYC_IMM_BYTE     4'h2
`define CMSD_CYC_IMM_WORD     4'h3
`define CMSD_CYC_EXT          4'h4
`define CMSD_CYC_CODE         4'h4
`define CMSD_CYC_JUMP         4'h3

`endif

// file: cmsd_pkg.sv
package cmsd_pkg;

    // access mode supplied by the execution unit
    typedef enum logic [3:0] {
        CMSD_M_REG       = 4'h0,
        CMSD_M_DIRECT    = 4'h1,
        CMSD_M_INDIRECT  = 4'h2,
        CMSD_M_BIT       = 4'h3,
        CMSD_M_IMM_BYTE  = 4'h4,
        CMSD_M_IMM_WORD  = 4'h5,
        CMSD_M_EXT_DATA_POINTER_PAIR  = 4'h6,
        CMSD_M_EXT_REG   = 4'h7,
        CMSD_M_CODE_DATA_POINTER_PAIR = 4'h8,
        CMSD_M_CODE_PC   = 4'h9,
        CMSD_M_JUMP      = 4'hA
    } cmsd_mode_e;

    // memory space actually reached
    typedef enum logic [2:0] {
        CMSD_T_NONE   = 3'h0,
        CMSD_T_IRAM   = 3'h1,
        CMSD_T_SFR    = 3'h2,
        CMSD_T_BITRAM = 3'h3,
        CMSD_T_EXTENDED_RAM   = 3'h4,
        CMSD_T_CODE   = 3'h5
    } cmsd_target_e;

    typedef enum logic [1:0] {
        CMSD_S_IDLE = 2'b01,
        CMSD_S_WAIT = 2'b10
    } cmsd_state_e;

endpackage

// file: cmsd_core_mem.sv
`timescale 1ns/1ps
`include "cmsd_map.svh"

module cmsd_core_mem #(
    parameter int CODE_BYTES = `CMSD_CODE_BYTES,
    parameter int EXTENDED_RAM_BYTES = `CMSD_EXTENDED_RAM_BYTES,
    parameter int P2_PINS    = `CMSD_PORT_TWO_PINS
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // access request from the execution unit
    input  wire logic                       req,
    input  wire cmsd_pkg::cmsd_mode_e       mode,
    input  wire logic                       wr,
    input  wire logic [7:0]                 addr,
    input  wire logic [7:0]                 wdata,
    input  wire logic                       wbit,
    input  wire logic [7:0]                 working_reg_zero,
    input  wire logic [15:0]                data_pointer_pair,
    input  wire logic [7:0]                 acc,
    input  wire logic [15:0]                pc,
    // answer
    output logic                            busy,
    output logic                            done,
    output logic [15:0]                     rdata,
    output logic                            rbit,
    output logic [15:0]                     jump_addr,
    output cmsd_pkg::cmsd_target_e          target,
    // code memory loading by the flash controller
    input  wire logic                       prog_we,
    input  wire logic [15:0]                prog_addr,
    input  wire logic [7:0]                 prog_wdata,
    // control register views
    output logic [7:0]                      legacy_power_control,
    output logic [7:0]                      power_mgmt_control,
    output logic [7:0]                      stack_pointer_high,
    output logic [10:0]                     stack_base,
    // general-purpose pins
    input  wire logic [15+P2_PINS:0]        gpio_in,
    output logic [15+P2_PINS:0]             gpio_out,
    output logic [15+P2_PINS:0]             gpio_oe,
    output logic [15+P2_PINS:0]             gpio_pullup
);

    localparam int NPIN = 16 + P2_PINS;
    localparam int XAW  = $clog2(EXTENDED_RAM_BYTES);

    if (P2_PINS < 1 || P2_PINS > 8 || CODE_BYTES < 1 || CODE_BYTES > 65536
        || EXTENDED_RAM_BYTES < 2 || EXTENDED_RAM_BYTES > 2048 || (1 << XAW) != EXTENDED_RAM_BYTES) begin : g_chk
        $error("cmsd_core_mem: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_s1_r;
    logic rst_n_i;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_n_i  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_i  <= rst_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // storage: all on chip, no external bus

    logic [7:0] iram [0:255];                                        // RL1
    logic [7:0] extended_ram [0:EXTENDED_RAM_BYTES-1];                               // RL7 RL8
    logic [7:0] code_mem [0:CODE_BYTES-1];                           // RL8

    function automatic logic [7:0] code_rd(input logic [15:0] a);
        code_rd = (32'(a) < CODE_BYTES) ? code_mem[a] : `CMSD_CODE_BLANK;
    endfunction

    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        bit_byte = `CMSD_BIT_RAM_BASE + {4'h0, b[6:3]};               // RL5
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request capture and timing

    cmsd_pkg::cmsd_state_e state_r;
    cmsd_pkg::cmsd_mode_e  mode_r;
    logic [3:0]            cnt_r;
    logic                  wr_r;
    logic                  wbit_r;
    logic [7:0]            addr_r;
    logic [7:0]            wdata_r;
    logic [7:0]            ri_r;
    logic [15:0]           data_pointer_pair_r;
    logic [7:0]            acc_r;
    logic [15:0]           pc_r;
    logic [3:0]            cyc_req;
    logic                  accept;
    logic                  finish;

    always_comb begin
        case (mode)
            cmsd_pkg::CMSD_M_REG:       cyc_req = `CMSD_CYC_REG;         // RL13
            cmsd_pkg::CMSD_M_DIRECT:    cyc_req = `CMSD_CYC_DIRECT;      // RL13
            cmsd_pkg::CMSD_M_INDIRECT:  cyc_req = `CMSD_CYC_INDIRECT;    // RL13
            cmsd_pkg::CMSD_M_BIT:       cyc_req = `CMSD_CYC_BIT;
            cmsd_pkg::CMSD_M_IMM_BYTE:  cyc_req = `CMSD_CYC_IMM_BYTE;    // RL12
            cmsd_pkg::CMSD_M_IMM_WORD:  cyc_req = `CMSD_CYC_IMM_WORD;    // RL12
            cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR:  cyc_req = `CMSD_CYC_EXT;         // RL10
            cmsd_pkg::CMSD_M_EXT_REG:   cyc_req = `CMSD_CYC_EXT;         // RL11
            cmsd_pkg::CMSD_M_JUMP:      cyc_req = `CMSD_CYC_JUMP;        // RL9
            default:                    cyc_req = `CMSD_CYC_CODE;        // RL9
        endcase
    end

    assign accept = req && (state_r == cmsd_pkg::CMSD_S_IDLE);
    assign finish = (state_r == cmsd_pkg::CMSD_S_WAIT) && (cnt_r == 4'h1);
    assign busy   = (state_r == cmsd_pkg::CMSD_S_WAIT);

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= cmsd_pkg::CMSD_S_IDLE;
            cnt_r   <= 4'h0;
        end else begin
            case (state_r)
                cmsd_pkg::CMSD_S_IDLE: begin
                    if (req) begin
                        state_r <= cmsd_pkg::CMSD_S_WAIT;
                        cnt_r   <= cyc_req;
                    end
                end
                cmsd_pkg::CMSD_S_WAIT: begin
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_r <= cmsd_pkg::CMSD_S_IDLE;
                    end
                end
                default: state_r <= cmsd_pkg::CMSD_S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r  <= cmsd_pkg::CMSD_M_REG;
            wr_r    <= 1'b0;
            wbit_r  <= 1'b0;
            addr_r  <= 8'h00;
            wdata_r <= 8'h00;
            ri_r    <= 8'h00;
            data_pointer_pair_r  <= 16'h0000;
            acc_r   <= 8'h00;
            pc_r    <= 16'h0000;
        end else if (accept) begin
            mode_r  <= mode;
            wr_r    <= wr;
            wbit_r  <= wbit;
            addr_r  <= addr;
            wdata_r <= wdata;
            ri_r    <= working_reg_zero;
            data_pointer_pair_r  <= data_pointer_pair;
            acc_r   <= acc;
            pc_r    <= pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic             is_bit;
    logic             bit_in_ram;
    logic             to_sfr;
    logic [7:0]       iram_a;
    logic [7:0]       sfr_a;
    logic [XAW-1:0]   extended_ram_a;
    logic [15:0]      code_a;
    logic [15:0]      jump_a;
    logic             bit_ok;

    assign is_bit     = (mode_r == cmsd_pkg::CMSD_M_BIT);
    assign bit_in_ram = is_bit && !addr_r[7];                                  // RL5
    assign to_sfr     = ((mode_r == cmsd_pkg::CMSD_M_DIRECT) && addr_r[7])     // RL2
                     || (is_bit && addr_r[7]);
    assign iram_a     = (mode_r == cmsd_pkg::CMSD_M_INDIRECT) ? ri_r           // RL3 RL4
                      : bit_in_ram ? bit_byte(addr_r) : addr_r;
    assign sfr_a      = is_bit ? {addr_r[7:3], 3'h0} : addr_r;
    assign extended_ram_a     = (mode_r == cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR)
                      ? data_pointer_pair_r[XAW-1:0]                                        // RL10 RL17
                      : XAW'(ri_r);                                            // RL11
    assign jump_a     = {8'h00, acc_r} + data_pointer_pair_r;                               // RL9
    assign code_a     = (mode_r == cmsd_pkg::CMSD_M_CODE_PC)
                      ? {8'h00, acc_r} + pc_r : jump_a;                        // RL9
    // only the port registers take single-bit operations
    assign bit_ok     = (sfr_a == `CMSD_SFR_PORT_ZERO) || (sfr_a == `CMSD_SFR_PORT_ONE)
                     || (sfr_a == `CMSD_SFR_PORT_TWO);                         // RL6 RL14

    ////////////////////////////////////////////////////////////////////////////
    // special function registers

    logic [7:0]      pwr_r;
    logic [7:0]      pmg_r;
    logic [7:0]      sph_r;
    logic [7:0]      lat0_r;
    logic [7:0]      lat1_r;
    logic [7:0]      lat2_r;
    logic [7:0]      pu1_r;
    logic [7:0]      pu2_r;
    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [NPIN-1:0] pin_s3_r;
    logic [NPIN-1:0] pin_q_r;
    logic [7:0]      pin2_byte;
    logic [7:0]      sfr_rd;
    logic [7:0]      sfr_wv;
    logic            sfr_we;

    assign pin2_byte = {{(8 - P2_PINS){1'b0}}, pin_q_r[NPIN-1:16]};

    always_comb begin
        case (sfr_a)
            `CMSD_SFR_PORT_ZERO:  sfr_rd = pin_q_r[7:0];                       // RL14
            `CMSD_SFR_PORT_ONE:   sfr_rd = pin_q_r[15:8];
            `CMSD_SFR_PORT_TWO:   sfr_rd = pin2_byte;
            `CMSD_SFR_LEGACY_PWR: sfr_rd = pwr_r;
            `CMSD_SFR_POWER_MGMT: sfr_rd = pmg_r;
            `CMSD_SFR_STACK_HIGH: sfr_rd = sph_r;
            `CMSD_SFR_PULLUP_ONE: sfr_rd = pu1_r;
            `CMSD_SFR_PULLUP_TWO: sfr_rd = pu2_r;
            default:              sfr_rd = 8'h00;
        endcase
    end

    // a bit write merges into the latch, never into the pins
    logic [7:0] lat_sel;
    always_comb begin
        case (sfr_a)
            `CMSD_SFR_PORT_ONE: lat_sel = lat1_r;
            `CMSD_SFR_PORT_TWO: lat_sel = lat2_r;
            default:            lat_sel = lat0_r;
        endcase
        sfr_wv = is_bit ? lat_sel : wdata_r;
        if (is_bit) begin
            sfr_wv[addr_r[2:0]] = wbit_r;
        end
    end

    assign sfr_we = finish && wr_r && to_sfr && (!is_bit || bit_ok);           // RL6

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_r  <= `CMSD_RST_LEGACY_PWR;
            pmg_r  <= `CMSD_RST_POWER_MGMT;
            sph_r  <= `CMSD_RST_STACK_HIGH;
            lat0_r <= `CMSD_RST_PORT_LATCH;
            lat1_r <= `CMSD_RST_PORT_LATCH;
            lat2_r <= `CMSD_RST_PORT_LATCH;
            pu1_r  <= `CMSD_RST_PULLUP;
            pu2_r  <= `CMSD_RST_PULLUP;
        end else if (sfr_we) begin
            case (sfr_a)
                `CMSD_SFR_PORT_ZERO:  lat0_r <= sfr_wv;
                `CMSD_SFR_PORT_ONE:   lat1_r <= sfr_wv;
                `CMSD_SFR_PORT_TWO:   lat2_r <= sfr_wv;
                `CMSD_SFR_LEGACY_PWR: pwr_r  <= sfr_wv;
                `CMSD_SFR_POWER_MGMT: pmg_r  <= sfr_wv;
                `CMSD_SFR_STACK_HIGH: sph_r  <= sfr_wv;
                `CMSD_SFR_PULLUP_ONE: pu1_r  <= sfr_wv;
                `CMSD_SFR_PULLUP_TWO: pu2_r  <= sfr_wv;
                default:              pwr_r  <= pwr_r;
            endcase
        end
    end

    // pins: three stages, a change is taken once stages two and three agree
    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_q_r  <= '0;
        end else begin
            pin_s1_r <= gpio_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_q_r  <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_q_r & (pin_s2_r ^ pin_s3_r));
        end
    end

    // pins only ever pull low; a high comes from the pull-up or the outside
    logic [NPIN-1:0] latch_all;
    logic [NPIN-1:0] pu_all;
    assign latch_all   = {lat2_r[P2_PINS-1:0], lat1_r, lat0_r};
    assign pu_all      = {pu2_r[P2_PINS-1:0], pu1_r, 8'h00};                   // RL15
    assign gpio_out    = '0;
    assign gpio_oe     = ~latch_all;                                           // RL15
    assign gpio_pullup = latch_all & pu_all;                                   // RL15

    assign legacy_power_control = pwr_r;
    assign power_mgmt_control   = pmg_r;
    assign stack_pointer_high   = sph_r;
    assign stack_base = {sph_r[`CMSD_SSA_MSB:`CMSD_SSA_LSB], 8'h00};         // RL16

    ////////////////////////////////////////////////////////////////////////////
    // memory writes and the answer

    logic         iram_we;
    logic         extended_ram_we;
    logic [7:0]   iram_wv;
    logic [15:0]  rd_val;
    logic [7:0]   byte_rd;
    cmsd_pkg::cmsd_target_e tgt;

    assign iram_we = finish && wr_r && !to_sfr && ((mode_r == cmsd_pkg::CMSD_M_REG)
                  || (mode_r == cmsd_pkg::CMSD_M_DIRECT)
                  || (mode_r == cmsd_pkg::CMSD_M_INDIRECT) || bit_in_ram);     // RL4
    assign extended_ram_we = finish && wr_r && ((mode_r == cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR)
                  || (mode_r == cmsd_pkg::CMSD_M_EXT_REG));                    // RL7

    always_comb begin
        iram_wv = bit_in_ram ? iram[iram_a] : wdata_r;
        if (bit_in_ram) begin
            iram_wv[addr_r[2:0]] = wbit_r;                                     // RL5
        end
    end

    always_ff @(posedge clk) begin
        if (iram_we) begin
            iram[iram_a] <= iram_wv;
        end
        if (extended_ram_we) begin
            extended_ram[extended_ram_a] <= wdata_r;
        end
        if (prog_we && (32'(prog_addr) < CODE_BYTES)) begin
            code_mem[prog_addr] <= prog_wdata;
        end
    end

    assign byte_rd = to_sfr ? sfr_rd : iram[iram_a];

    always_comb begin
        rd_val = {8'h00, byte_rd};
        tgt    = to_sfr ? cmsd_pkg::CMSD_T_SFR : cmsd_pkg::CMSD_T_IRAM;
        case (mode_r)
            cmsd_pkg::CMSD_M_BIT: begin
                if (!to_sfr) begin
                    tgt = cmsd_pkg::CMSD_T_BITRAM;
                end
            end
            cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR, cmsd_pkg::CMSD_M_EXT_REG: begin
                rd_val = {8'h00, extended_ram[extended_ram_a]};
                tgt    = cmsd_pkg::CMSD_T_EXTENDED_RAM;
            end
            cmsd_pkg::CMSD_M_IMM_BYTE: begin
                rd_val = {8'h00, code_rd(pc_r + 16'h0001)};                    // RL12
                tgt    = cmsd_pkg::CMSD_T_CODE;
            end
            cmsd_pkg::CMSD_M_IMM_WORD: begin
                rd_val = {code_rd(pc_r + 16'h0001), code_rd(pc_r + 16'h0002)}; // RL12
                tgt    = cmsd_pkg::CMSD_T_CODE;
            end
            cmsd_pkg::CMSD_M_CODE_DATA_POINTER_PAIR, cmsd_pkg::CMSD_M_CODE_PC: begin
                rd_val = {8'h00, code_rd(code_a)};                             // RL9
                tgt    = cmsd_pkg::CMSD_T_CODE;
            end
            cmsd_pkg::CMSD_M_JUMP: begin
                rd_val = jump_a;
                tgt    = cmsd_pkg::CMSD_T_CODE;
            end
            default: begin
                rd_val = {8'h00, byte_rd};
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done      <= 1'b0;
            rdata     <= 16'h0000;
            rbit      <= 1'b0;
            jump_addr <= 16'h0000;
            target    <= cmsd_pkg::CMSD_T_NONE;
        end else begin
            done <= finish;
            if (finish) begin
                rdata     <= rd_val;
                rbit      <= byte_rd[addr_r[2:0]];
                jump_addr <= jump_a;
                target    <= tgt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_DIRECT_SFR: assert property (@(posedge clk) disable iff (!rst_n_i) // RL2
        done && (mode_r == cmsd_pkg::CMSD_M_DIRECT) && addr_r[7] |-> target == cmsd_pkg::CMSD_T_SFR)
        else $error("direct upper access missed the special function space");

    AST_INDIRECT_RAM: assert property (@(posedge clk) disable iff (!rst_n_i) // RL3
        done && (mode_r == cmsd_pkg::CMSD_M_INDIRECT) |-> target == cmsd_pkg::CMSD_T_IRAM)
        else $error("indirect access left internal RAM");

    AST_BIT_AREA: assert property (@(posedge clk) disable iff (!rst_n_i) // RL5
        finish && bit_in_ram |-> iram_a == (8'h20 + {4'h0, addr_r[6:3]}))
        else $error("bit address decoded to wrong RAM byte");

    AST_PWR_NO_BIT: assert property (@(posedge clk) disable iff (!rst_n_i) // RL6
        !(sfr_we && !is_bit && (sfr_a == 8'h87)) |=> $stable(pwr_r))
        else $error("legacy power control changed without a byte write");

    AST_CODE_TIME: assert property (@(posedge clk) disable iff (!rst_n_i) // RL9
        accept && (mode == cmsd_pkg::CMSD_M_CODE_DATA_POINTER_PAIR) |=> !done [*4] ##1 done)
        else $error("code read not answered in four cycles");

    AST_JUMP_TIME: assert property (@(posedge clk) disable iff (!rst_n_i) // RL9
        accept && (mode == cmsd_pkg::CMSD_M_JUMP) |-> ##4 done ##0 (target == cmsd_pkg::CMSD_T_CODE))
        else $error("indirect jump not answered in three cycles");

    AST_EXT_TIME: assert property (@(posedge clk) disable iff (!rst_n_i) // RL10
        accept && (mode == cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR) |-> ##5 done ##0 (target == cmsd_pkg::CMSD_T_EXTENDED_RAM))
        else $error("extended read not answered in four cycles");

    AST_REG_TIME: assert property (@(posedge clk) disable iff (!rst_n_i) // RL13
        accept && (mode == cmsd_pkg::CMSD_M_REG) |-> ##2 done)
        else $error("register move not answered in one cycle");

    AST_IMM_WORD_TIME: assert property (@(posedge clk) disable iff (!rst_n_i) // RL12
        accept && (mode == cmsd_pkg::CMSD_M_IMM_WORD) |-> ##3 !done ##1 done)
        else $error("immediate word not answered in three cycles");

    AST_PORT0_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_n_i) // RL15
        gpio_pullup[7:0] == 8'h00 && (gpio_oe == ~latch_all))
        else $error("port zero pull-up or pin drive wrong");

    AST_STACK_BASE: assert property (@(posedge clk) disable iff (!rst_n_i) // RL16
        sfr_we && (sfr_a == 8'hB7) |=> stack_base[10:8] == $past(sfr_wv[5:3]))
        else $error("stack start bits not applied");

endmodule // cmsd_core_mem

// file: cmsd_exec_model.sv
`timescale 1ns/1ps
module cmsd_exec_model (
    // clock, and the answer from the block
    input  wire logic            clk,
    input  wire logic            busy,
    input  wire logic            done,
    // request to the block
    output logic                 req,
    output cmsd_pkg::cmsd_mode_e mode,
    output logic                 wr,
    output logic [7:0]           addr,
    output logic [7:0]           wdata,
    output logic                 wbit,
    output logic [7:0]           working_reg_zero,
    output logic [15:0]          data_pointer_pair,
    output logic [7:0]           acc,
    output logic [15:0]          pc
);
    initial begin
        mode = cmsd_pkg::CMSD_M_REG;
        {req, wr, wbit, addr, wdata, working_reg_zero, data_pointer_pair, acc, pc} = '0;
    end
    // called at a rising edge; returns at the edge that samples done
    task automatic op(cmsd_pkg::cmsd_mode_e m, logic w, logic [7:0] a, d, logic [15:0] p,
                      logic [7:0] ac);
        int n;
        mode <= m;
        wr <= w;
        addr <= a;
        wdata <= d;
        wbit <= d[0];
        working_reg_zero <= p[7:0];
        data_pointer_pair <= p;
        pc <= p;
        acc <= ac;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        // released addr and wdata stop showing the old value
        addr <= ~a;
        wdata <= ~d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 20);
    endtask
endmodule // cmsd_exec_model

// file: cmsd_core_mem_tb_top.sv
`timescale 1ns/1ps
module cmsd_core_mem_tb_top;
    typedef struct {logic [15:0] d; logic [2:0] t; logic [3:0] n; logic w;} cmsd_exp_s;
    logic clk, rstn, req, wr, wbit, busy, done, rbit, prog_we;
    cmsd_pkg::cmsd_mode_e   mode;
    cmsd_pkg::cmsd_target_e target;
    logic [7:0]  addr, wdata, working_reg_zero, acc, prog_wdata, cb [4];
    logic [7:0]  legacy_power_control, power_mgmt_control, stack_pointer_high;
    logic [15:0] data_pointer_pair, pc, rdata, jump_addr, prog_addr, r, seed = 16'hECE7;
    logic [10:0] stack_base;
    logic [19:0] gpio_in, gpio_out, gpio_oe, gpio_pullup;
    int          err_count = 0, checks = 0, lat = 0;
    cmsd_exp_s   q [$], e;
    cmsd_core_mem dut (.*);
    cmsd_exec_model ex (.*);
    function automatic logic [15:0] xs();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic chk(string nm, logic [19:0] s, x);
        checks++;
        if (s !== x) begin
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
            err_count++;
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic go(cmsd_pkg::cmsd_mode_e m, logic w, logic [7:0] a, d, logic [15:0] p,
                      logic [7:0] ac, logic [15:0] ed, logic [2:0] et, logic [3:0] n);
        q.push_back('{ed, et, n, w});
        ex.op(m, w, a, d, p, ac);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        stop_test();
    end
    // answers are matched against the oldest note
    always @(posedge clk) begin
        if (done === 1'b1) begin
            e = q.pop_front();
            chk("cycles", 20'(lat), 20'(e.n));
            if (!e.w) chk("rdata", 20'(rdata), 20'(e.d));
            if (e.t != 3'h7) chk("target", 20'(target), 20'(e.t));
        end
        if (q.size() && !done && !req && lat < q[0].n) chk("busy", 20'(busy), 20'h1);
        lat = (req && !busy) ? 0 : lat + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, prog_we, prog_addr, prog_wdata, gpio_in} = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        gpio_in <= {xs(), 4'h5};
        repeat (3) @(posedge clk);
        chk("stack_base", 20'(stack_base), 20'h00100);
        chk("pullup", gpio_pullup, 20'hFFF00);
        chk("oe", gpio_oe | gpio_out, 20'h00000);
        r = xs();
        go(cmsd_pkg::CMSD_M_REG, 1, 8'h05, r[7:0], 0, 0, 0, 1, 4'h1);
        go(cmsd_pkg::CMSD_M_INDIRECT, 0, 0, 0, 16'h0005, 0, r[7:0], 1, 4'h2);
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'h30, r[15:8], 0, 0, 0, 1, 4'h2);
        go(cmsd_pkg::CMSD_M_INDIRECT, 1, 0, r[7:0], 16'h0090, 0, 0, 1, 4'h2);
        go(cmsd_pkg::CMSD_M_INDIRECT, 0, 0, 0, 16'h0090, 0, r[7:0], 1, 4'h2);
        go(cmsd_pkg::CMSD_M_DIRECT, 0, 8'h90, 0, 0, 0, gpio_in[15:8], 2, 4'h2);
        go(cmsd_pkg::CMSD_M_INDIRECT, 0, 0, 0, 16'h0030, 0, r[15:8], 1, 4'h2);
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'h21, 0, 0, 0, 0, 1, 4'h2);
        go(cmsd_pkg::CMSD_M_BIT, 1, 8'h0B, 1, 0, 0, 0, 3, 4'h2);
        go(cmsd_pkg::CMSD_M_BIT, 0, 8'h0B, 0, 0, 0, 16'h0008, 3, 4'h2);
        chk("rbit", 20'(rbit), 20'h00001);
        go(cmsd_pkg::CMSD_M_DIRECT, 0, 8'h21, 0, 0, 0, 16'h0008, 1, 4'h2);
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'h87, r[15:8], 0, 0, 0, 2, 4'h2);
        chk("power", 20'(legacy_power_control), 20'(r[15:8]));
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'hC5, r[7:0], 0, 0, 0, 2, 4'h2);
        chk("pmg", 20'(power_mgmt_control), 20'(r[7:0]));
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'hB7, 8'h30, 0, 0, 0, 2, 4'h2);
        chk("stack", 20'(stack_base), 20'h00600);
        chk("sph", 20'(stack_pointer_high), 20'h00030);
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'hE1, 0, 0, 0, 0, 2, 4'h2);
        go(cmsd_pkg::CMSD_M_DIRECT, 1, 8'h90, 8'hFE, 0, 0, 0, 2, 4'h2);
        chk("oe_clr", gpio_oe | gpio_pullup, 20'hF0100);
        go(cmsd_pkg::CMSD_M_BIT, 1, 8'h90, 1, 0, 0, 0, 2, 4'h2);
        chk("oe_set", gpio_oe, 20'h00000);
        gpio_in <= {xs(), 4'hA};
        go(cmsd_pkg::CMSD_M_EXT_DATA_POINTER_PAIR, 1, 0, r[7:0], 16'h0880, 0, 0, 4, 4'h4);
        go(cmsd_pkg::CMSD_M_EXT_REG, 0, 0, 0, 16'h0080, 0, r[7:0], 4, 4'h4);
        go(cmsd_pkg::CMSD_M_DIRECT, 0, 8'h80, 0, 0, 0, gpio_in[7:0], 2, 4'h2);
        for (int i = 0; i < 4; i++) begin
            cb[i] = 8'(xs());
            prog_we <= 1'b1;
            prog_addr <= 16'h8000 + 16'(i);
            prog_wdata <= cb[i];
            @(posedge clk);
        end
        prog_we <= 1'b0;
        go(cmsd_pkg::CMSD_M_CODE_DATA_POINTER_PAIR, 0, 0, 0, 16'h8000, 2, cb[2], 5, 4'h4);
        go(cmsd_pkg::CMSD_M_CODE_PC, 0, 0, 0, 16'h8001, 2, cb[3], 5, 4'h4);
        go(cmsd_pkg::CMSD_M_JUMP, 0, 0, 0, 16'h8000, 3, 16'h8003, 5, 4'h3);
        chk("jump", 20'(jump_addr), 20'h08003);
        go(cmsd_pkg::CMSD_M_IMM_BYTE, 0, 0, 0, 16'h7FFF, 0, cb[0], 5, 4'h2);
        go(cmsd_pkg::CMSD_M_IMM_WORD, 0, 0, 0, 16'h8000, 0, {cb[1], cb[2]}, 5, 4'h3);
        repeat (3) @(posedge clk);
        chk("left", 20'(q.size()), 20'h00000);
        stop_test();
    end
endmodule // cmsd_core_mem_tb_top
